// ### hdl/hmc_pkg.sv
// Constants shared by the Hall measurement control block.
// Assumes a 16-bit parallel register port fed by the serial interface block.
package hmc_pkg;
  // Register word addresses.
  localparam logic [8:0] ADDR_CFG_A = 9'h001;
  localparam logic [8:0] ADDR_CFG_B = 9'h002;
  localparam logic [8:0] ADDR_SPIN = 9'h004;
  localparam logic [8:0] ADDR_OUT_OPT = 9'h005;
  localparam logic [8:0] ADDR_BG_TEMP = 9'h00B;
  localparam logic [8:0] ADDR_RESULT_LOW = 9'h100;
  localparam logic [8:0] ADDR_RESULT_STAT = 9'h102;
  localparam logic [8:0] ADDR_TEMP_RES = 9'h104;
  // Reset value of every register.
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Field positions of measure_config_a.
  localparam int START_BIT = 0;
  localparam int LEN_LO_MSB = 7;
  localparam int LEN_LO_LSB = 1;
  localparam int SENSOR_MSB = 11;
  localparam int SENSOR_LSB = 8;
  localparam int TEMP_SEL_BIT = 12;
  // Field positions of measure_config_b.
  localparam int WAIT_MSB = 7;
  localparam int WAIT_LSB = 0;
  localparam int LEN_HI_MSB = 10;
  localparam int LEN_HI_LSB = 8;
  localparam int TWO_PHASE_BIT = 12;
  // Field positions of spinning_config.
  localparam int SIGNS_MSB = 12;
  localparam int SIGNS_LSB = 9;
  // Field positions of output_options.
  localparam int ALT_READ_BIT = 0;
  localparam int PIN_PERM_BIT = 1;
  localparam int PIN_OD_BIT = 2;
  localparam int PARITY_EN_BIT = 3;
  localparam int SEQ_EN_BIT = 4;
  localparam int RANGE_EN_BIT = 5;
  // Field positions of background_temp_config and result_status.
  localparam int BG_MSB = 3;
  localparam int BG_LSB = 0;
  localparam int READY_BIT = 15;
  // Readout forced on a range warning in alternate readout mode.
  localparam logic [15:0] RANGE_FORCED = 16'h7FFF;
  // Number of settle cycles skipped before background temperature sampling.
  localparam logic [8:0] BG_SKIP = 9'h002;
  // Measurement states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_BREAK = 6'b000010,
    ST_SETTLE = 6'b000100,
    ST_DECIM = 6'b001000,
    ST_SUM = 6'b010000,
    ST_HOLD = 6'b100000
  } hmc_state_t;
endpackage

// ### hdl/hmc_control.sv
// Hall measurement control: register set, phase sequencing, decimation and result publication.
// Assumes the serial interface block hands over word accesses on REG_* already in the REF_CLK domain.
// What this block does
// - Start bit launches, clearing it aborts decimation.
// - Phase selections switch break-before-make.
// - Settle-wait cycles precede every decimation.
// - Decimation length assembled from two words.
// - Zero length field means one clock.
// - Accumulate modulator bits into phase value.
// - Completion sets ready flag, pin, result.
// - Reading result word clears ready, frees buffer.
// - Result MSB sits in status bits 1-0.
// - Ready pin drive mode selectable.
// - Nonzero sign field enables four-phase spinning.
// - Four phases stepped and signed-summed automatically.
// - Temperature measurements always use two phases.
// - Two-phase bit enables two-phase spinning.
// - Background temperature runs during wait cycles.
// - Temperature result valid after two windows.
// - Alternate readout returns result on word 1.
// - Range warning forces alternate readout 7FFF.
// - Alternate mode write clears ready.
// - Status bits inserted from result MSB.
// - All readable registers reset to zero.
`timescale 1ns/1ns
module hmc_control
  import hmc_pkg::*;
(
  input wire logic REF_CLK, // System clock, 10 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic [8:0] REG_ADDR, // Word address of a register access.
  input wire logic [15:0] REG_WDATA, // Write data.
  input wire logic REG_WR, // One-cycle write strobe.
  input wire logic REG_RD, // One-cycle read strobe.
  output logic [15:0] REG_RDATA, // Read data, valid the cycle after REG_RD.
  input wire logic MOD_BIT, // Sigma-delta modulator output bit.
  input wire logic RANGE_WARN, // Range warning from the front end.
  input wire logic [1:0] SEQ_NUM, // Sequence number for insertion.
  input wire logic CS_N_PIN, // Chip select pin, asynchronous.
  output logic [3:0] SENSOR_SEL, // Selected sensor.
  output logic TEMP_SEL, // Temperature sensor routed to modulator.
  output logic [3:0] PHASE_SEL, // One-hot Hall phase selection.
  output logic MOD_EN, // Modulator decimation window.
  output logic BG_TEMP_ACTIVE, // Background temperature sampling.
  output logic READY_OUT, // Ready pin output level.
  output logic READY_OE_N // Ready pin output enable, low drives.
);

  // Inserts parity, sequence number and range warning from the MSB end.
  function automatic logic [15:0] hmc_insert(input logic [15:0] v, input logic p_en, input logic p,
                                             input logic s_en, input logic [1:0] s,
                                             input logic r_en, input logic r);
    logic [15:0] o;
    int pos;
    o = v;
    pos = 15;
    if (p_en) begin
      o[pos] = p;
      pos = pos - 1;
    end
    if (s_en) begin
      o[pos] = s[1];
      o[pos-1] = s[0];
      pos = pos - 2;
    end
    if (r_en) begin
      o[pos] = r;
    end
    return o;
  endfunction

  // Configuration registers.
  logic [15:0] cfg_a_reg, cfg_b_reg, spin_reg, opt_reg, bg_reg; // Software-written words.
  // Measurement state.
  hmc_state_t state_reg, state_next; // Control state.
  logic [8:0] settle_cnt_reg; // Settle cycles elapsed.
  logic [10:0] dec_cnt_reg; // Decimation cycles elapsed.
  logic [1:0] phase_reg; // Current phase index.
  logic [2:0] nphase_reg; // Phases of this measurement.
  logic meas_temp_reg; // Measurement is a temperature one.
  logic signed [16:0] phase_acc_reg; // Single-phase accumulator.
  logic signed [16:0] total_reg; // Signed sum over phases.
  logic rng_meas_reg; // Range warning seen in this measurement.
  // Published result.
  logic [16:0] result_reg; // Published result value.
  logic result_temp_reg; // Published result came from temperature.
  logic result_rng_reg; // Published result had a range warning.
  logic ready_reg; // Ready flag, buffer occupied.
  // Background temperature.
  logic signed [15:0] bg_acc_reg; // Background accumulator.
  logic [5:0] bg_phase_reg; // Background phases in window.
  logic bg_window_reg; // First window completed.
  logic [15:0] temp_res_reg; // Published temperature result.
  // Chip select synchroniser.
  logic [2:0] cs_sync_reg; // Three-stage chain.
  logic cs_high_reg; // Debounced chip select level.

  // Register access decode.
  wire wr_cfg_a = REG_WR && (REG_ADDR == ADDR_CFG_A);
  wire rd_result = REG_RD && (REG_ADDR == ADDR_RESULT_LOW);
  wire alt_en = opt_reg[ALT_READ_BIT];
  wire start_write = wr_cfg_a && REG_WDATA[START_BIT];
  wire abort_write = wr_cfg_a && !REG_WDATA[START_BIT];
  wire measuring = !(state_reg == ST_IDLE);

  // Decimation length and its effective value.
  wire [10:0] dec_len = {cfg_b_reg[LEN_HI_MSB:LEN_HI_LSB], cfg_a_reg[LEN_LO_MSB:LEN_LO_LSB], 1'b0};
  wire [10:0] eff_len = (dec_len == 11'h000) ? 11'h001 : dec_len;
  wire [8:0] settle_len = {1'b0, cfg_b_reg[WAIT_MSB:WAIT_LSB]};
  wire [3:0] signs = spin_reg[SIGNS_MSB:SIGNS_LSB];
  wire [3:0] bg_count = bg_reg[BG_MSB:BG_LSB];

  // Phase count chosen at launch: temperature first, then four, then two.
  wire start_temp = REG_WDATA[TEMP_SEL_BIT];
  wire [2:0] start_nphase = start_temp ? 3'h2 :
                            (signs != 4'h0) ? 3'h4 :
                            cfg_b_reg[TWO_PHASE_BIT] ? 3'h2 : 3'h1;

  // Step conditions.
  wire settle_done = ({1'b0, settle_cnt_reg} + 10'h001) >= {1'b0, settle_len};
  wire dec_done = (dec_cnt_reg + 11'h001) >= eff_len;
  wire last_phase = ({1'b0, phase_reg} + 3'h1) >= nphase_reg;
  // Sign of the current phase: four-phase uses the sign field, two-phase subtracts phase one.
  wire phase_neg = (nphase_reg == 3'h4) ? signs[2'h3 - phase_reg] :
                   (nphase_reg == 3'h2) ? phase_reg[0] : 1'b0;
  wire signed [16:0] mod_step = MOD_BIT ? 17'sh00001 : -17'sh00001;
  // An abort in the publish cycle wins, so a cancelled run never reaches the result buffer.
  wire publish = (state_reg == ST_HOLD) && !ready_reg && !abort_write;

  // Background temperature window.
  wire bg_on = (bg_count != 4'h0) && (state_reg == ST_SETTLE) && (settle_cnt_reg >= BG_SKIP);
  wire bg_slot_end = (bg_count != 4'h0) && (state_reg == ST_SETTLE) && settle_done;
  wire bg_window_end = bg_slot_end && ((bg_phase_reg + 6'h01) == {bg_count, 2'b00});
  wire signed [15:0] bg_step = (MOD_BIT ^ bg_phase_reg[0]) ? 16'sh0001 : -16'sh0001;

  // Readout values.
  wire [15:0] alt_value = result_rng_reg ? RANGE_FORCED :
                          result_temp_reg ? result_reg[15:0] : result_reg[16:1];
  wire [15:0] low_value = hmc_insert(result_reg[15:0], opt_reg[PARITY_EN_BIT], ^result_reg,
                                     opt_reg[SEQ_EN_BIT], SEQ_NUM, opt_reg[RANGE_EN_BIT],
                                     result_rng_reg);
  wire [15:0] status_value = {ready_reg, 13'h0000, result_reg[16], result_reg[16]};
  wire [15:0] rdata_next = (REG_ADDR == ADDR_CFG_A) ? (alt_en ? alt_value : cfg_a_reg) :
                           (REG_ADDR == ADDR_CFG_B) ? cfg_b_reg :
                           (REG_ADDR == ADDR_SPIN) ? spin_reg :
                           (REG_ADDR == ADDR_OUT_OPT) ? opt_reg :
                           (REG_ADDR == ADDR_BG_TEMP) ? bg_reg :
                           (REG_ADDR == ADDR_RESULT_LOW) ? low_value :
                           (REG_ADDR == ADDR_RESULT_STAT) ? status_value :
                           (REG_ADDR == ADDR_TEMP_RES) ? temp_res_reg : 16'h0000;

  // Next state of the measurement sequence.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_write) begin
          state_next = ST_BREAK;
        end
      end
      ST_BREAK: begin
        state_next = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_next = ST_DECIM;
        end
      end
      ST_DECIM: begin
        if (dec_done) begin
          state_next = ST_SUM;
        end
      end
      ST_SUM: begin
        state_next = last_phase ? ST_HOLD : ST_BREAK;
      end
      ST_HOLD: begin
        if (publish) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (abort_write && measuring) begin
      state_next = ST_IDLE;
    end
  end

  // Configuration registers; all start at zero.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cfg_a_reg <= REG_RESET;
      cfg_b_reg <= REG_RESET;
      spin_reg <= REG_RESET;
      opt_reg <= REG_RESET;
      bg_reg <= REG_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == ADDR_CFG_A) cfg_a_reg <= REG_WDATA;
      if (REG_ADDR == ADDR_CFG_B) cfg_b_reg <= REG_WDATA;
      if (REG_ADDR == ADDR_SPIN) spin_reg <= REG_WDATA;
      if (REG_ADDR == ADDR_OUT_OPT) opt_reg <= REG_WDATA;
      if (REG_ADDR == ADDR_BG_TEMP) bg_reg <= REG_WDATA;
    end
  end

  // State and counters of the sequence.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      settle_cnt_reg <= 9'h000;
      dec_cnt_reg <= 11'h000;
      phase_reg <= 2'h0;
      nphase_reg <= 3'h1;
      meas_temp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      settle_cnt_reg <= (state_reg == ST_SETTLE) ? settle_cnt_reg + 9'h001 : 9'h000;
      dec_cnt_reg <= (state_reg == ST_DECIM) ? dec_cnt_reg + 11'h001 : 11'h000;
      if (state_reg == ST_IDLE && start_write) begin
        phase_reg <= 2'h0;
        nphase_reg <= start_nphase;
        meas_temp_reg <= start_temp;
      end else if (state_reg == ST_SUM && !last_phase) begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // Decimation accumulator and phase summation.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      phase_acc_reg <= 17'sh00000;
      total_reg <= 17'sh00000;
      rng_meas_reg <= 1'b0;
    end else begin
      if (state_reg == ST_BREAK) begin
        phase_acc_reg <= 17'sh00000;
      end else if (state_reg == ST_DECIM) begin
        phase_acc_reg <= phase_acc_reg + mod_step;
      end
      if (state_reg == ST_IDLE) begin
        total_reg <= 17'sh00000;
      end else if (state_reg == ST_SUM) begin
        total_reg <= phase_neg ? total_reg - phase_acc_reg : total_reg + phase_acc_reg;
      end
      if (state_reg == ST_IDLE) begin
        rng_meas_reg <= 1'b0;
      end else if (RANGE_WARN) begin
        rng_meas_reg <= 1'b1;
      end
    end
  end

  // Result buffer and ready flag; a waiting result publishes once the buffer is free.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      result_reg <= 17'h00000;
      result_temp_reg <= 1'b0;
      result_rng_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      if (publish) begin
        result_reg <= total_reg;
        result_temp_reg <= meas_temp_reg;
        result_rng_reg <= rng_meas_reg;
        ready_reg <= 1'b1;
      end else if (rd_result || (alt_en && wr_cfg_a)) begin
        ready_reg <= 1'b0;
      end
    end
  end

  // Background temperature sampling during settle cycles.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      bg_acc_reg <= 16'sh0000;
      bg_phase_reg <= 6'h00;
      bg_window_reg <= 1'b0;
      temp_res_reg <= 16'h0000;
    end else if (bg_count == 4'h0) begin
      bg_acc_reg <= 16'sh0000;
      bg_phase_reg <= 6'h00;
      bg_window_reg <= 1'b0;
    end else begin
      if (bg_window_end) begin
        bg_acc_reg <= 16'sh0000;
        bg_phase_reg <= 6'h00;
        bg_window_reg <= 1'b1;
        if (bg_window_reg) begin
          temp_res_reg <= bg_acc_reg + (bg_on ? bg_step : 16'sh0000);
        end
      end else begin
        if (bg_on) begin
          bg_acc_reg <= bg_acc_reg + bg_step;
        end
        if (bg_slot_end) begin
          bg_phase_reg <= bg_phase_reg + 6'h01;
        end
      end
    end
  end

  // Read data register and chip select synchroniser.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
      cs_sync_reg <= 3'b111;
      cs_high_reg <= 1'b1;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= rdata_next;
      end
      cs_sync_reg <= {cs_sync_reg[1:0], CS_N_PIN};
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_high_reg <= cs_sync_reg[2];
      end
    end
  end

  // Analogue controls; phases drop to none in the break cycle between phases.
  assign SENSOR_SEL = cfg_a_reg[SENSOR_MSB:SENSOR_LSB];
  assign TEMP_SEL = (measuring && meas_temp_reg) || bg_on;
  assign PHASE_SEL = (state_reg == ST_SETTLE || state_reg == ST_DECIM) ? (4'h1 << phase_reg) : 4'h0;
  assign MOD_EN = (state_reg == ST_DECIM);
  assign BG_TEMP_ACTIVE = bg_on;
  // Ready pin: push-pull drives the flag, open drain only pulls low while not ready.
  assign READY_OUT = opt_reg[PIN_OD_BIT] ? 1'b0 : ready_reg;
  assign READY_OE_N = (!opt_reg[PIN_PERM_BIT] && cs_high_reg) ||
                      (opt_reg[PIN_OD_BIT] && ready_reg);

  // Checks on the sequence and the register behaviour.
  logic [8:0] settle_seen_reg; // Cycles seen in settle, for checking.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) settle_seen_reg <= 9'h000;
    else settle_seen_reg <= (state_reg == ST_SETTLE) ? settle_seen_reg + 9'h001 : 9'h000;
  end
  sequence s_start_idle;
    (state_reg == ST_IDLE) && start_write;
  endsequence
  sequence s_break_then_settle;
    (state_reg == ST_BREAK) && (PHASE_SEL == 4'h0) ##1 (state_reg == ST_SETTLE);
  endsequence
  a_start_launch: assert property (@(posedge REF_CLK) disable iff (RST)
    s_start_idle |=> s_break_then_settle) else $error("Start write did not launch a measurement.");
  a_phase_break: assert property (@(posedge REF_CLK) disable iff (RST)
    ($changed(PHASE_SEL) && PHASE_SEL != 4'h0) |-> $past(PHASE_SEL) == 4'h0)
    else $error("Phase selections overlapped.");
  a_settle_count: assert property (@(posedge REF_CLK) disable iff (RST)
    ((state_reg == ST_SETTLE) && (state_next == ST_DECIM) && settle_len >= 9'h003)
    |-> (settle_seen_reg + 9'h001) == settle_len) else $error("Settle length wrong.");
  a_short_decim: assert property (@(posedge REF_CLK) disable iff (RST)
    ((state_reg == ST_DECIM) && dec_len == 11'h000 && dec_cnt_reg == 11'h000) |=> state_reg != ST_DECIM)
    else $error("Zero length did not give one clock.");
  a_read_clears: assert property (@(posedge REF_CLK) disable iff (RST)
    (rd_result && ready_reg) |=> !ready_reg && !(READY_OUT && !READY_OE_N))
    else $error("Result read left ready set.");
  a_abort_quiet: assert property (@(posedge REF_CLK) disable iff (RST)
    (abort_write && measuring && !ready_reg) |=> (state_reg == ST_IDLE) ##1 !ready_reg)
    else $error("Abort published a result.");
  a_alt_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    (alt_en && wr_cfg_a && !publish) |=> !ready_reg) else $error("Alternate write kept ready.");
  a_pin_follow: assert property (@(posedge REF_CLK) disable iff (RST)
    (opt_reg[2:1] == 2'b01) |-> (READY_OUT == ready_reg) && !READY_OE_N)
    else $error("Permanent push-pull pin wrong.");
  a_temp_two: assert property (@(posedge REF_CLK) disable iff (RST)
    ((state_reg == ST_IDLE) && start_write && start_temp) |=> nphase_reg == 3'h2)
    else $error("Temperature not two-phase.");
  a_status_msb: assert property (@(posedge REF_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == ADDR_RESULT_STAT) |=> REG_RDATA[1:0] == {2{$past(result_reg[16])}}
    && REG_RDATA[15] == $past(ready_reg)) else $error("Status word wrong.");
endmodule // hmc_control

// ### sim/hmc_frontend_model.sv
// Behavioural analogue front end: one modulator bit per Hall phase and a range warning level.
// Assumes it shares the system clock with the control block and follows its phase selection.
`timescale 1ns/1ns
module hmc_frontend_model (
  input wire logic clk, // System clock.
  input wire logic [3:0] phase_sel, // One-hot phase from the block.
  input wire logic mod_en, // Decimation window.
  input wire logic temp_sel, // Temperature path selected.
  input wire logic [3:0] pattern, // Modulator bit for each phase.
  input wire logic warn, // Range warning to raise.
  output logic mod_bit, // Modulator output bit.
  output logic range_warn // Range warning level.
);
  logic tog = 1'b0; // Filler level used outside sampling.
  // Outside sampling the bit alternates, so a stale level is never taken for data.
  always @(posedge clk) begin
    tog <= ~tog;
  end
  // The bit follows the phase pattern while the block samples it.
  assign mod_bit = (mod_en || temp_sel) ? |(pattern & phase_sel) : tog;
  assign range_warn = warn;
endmodule // hmc_frontend_model

// ### sim/hall_measurement_control_test.sv
// Self-checking bench for the Hall measurement control block.
// Assumes the front end model in hmc_frontend_model.sv and one 10 MHz clock.
`timescale 1ns/1ns
module hall_measurement_control_test
  import hmc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cs_n = 1'b1, warn = 1'b0;
  logic [8:0] addr = 9'h000; // Register address.
  logic [15:0] wdata = 16'h0000; // Write data.
  logic [1:0] seq = 2'b00; // Sequence number.
  logic [3:0] pat = 4'h0; // Modulator pattern per phase.
  logic [15:0] rdata, v; // Read data and last read value.
  logic [3:0] sensor, phase, prev_phase = 4'h0; // Sensor and phase selections.
  logic temp_sel, mod_en, bg_act, rdy_out, rdy_oe_n, mod_bit, range_warn;
  int error_cnt = 0, total_checks = 0, n_dec = 0, n_set = 0, n_bg = 0, n_tmp = 0;
  hmc_control dut (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .MOD_BIT(mod_bit), .RANGE_WARN(range_warn), .SEQ_NUM(seq), .CS_N_PIN(cs_n),
    .SENSOR_SEL(sensor), .TEMP_SEL(temp_sel), .PHASE_SEL(phase), .MOD_EN(mod_en), .BG_TEMP_ACTIVE(bg_act),
    .READY_OUT(rdy_out), .READY_OE_N(rdy_oe_n));
  hmc_frontend_model fe (.clk(clk), .phase_sel(phase), .mod_en(mod_en), .temp_sel(temp_sel), .pattern(pat),
    .warn(warn), .mod_bit(mod_bit), .range_warn(range_warn));
  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end
  // Compares a value and counts any mismatch.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Counts settle, decimation and background cycles and watches every phase change.
  always @(posedge clk) begin
    if (mod_en === 1'b1) n_dec++;
    if (phase !== 4'h0 && mod_en === 1'b0) n_set++;
    if (bg_act === 1'b1) n_bg++;
    if (temp_sel === 1'b1) n_tmp++;
    if (!$onehot0(phase) || (prev_phase != 4'h0 && phase != 4'h0 && phase != prev_phase)) begin
      chk("phase switch", {12'h000, phase}, 16'h0000);
    end
    prev_phase <= phase;
  end
  // One-cycle write strobe.
  task automatic wreg(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is taken once the answering edge has landed.
  task automatic rreg(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Reads a register and compares it.
  task automatic rchk(input logic [8:0] a, input logic [15:0] exp);
    rreg(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask
  // Starts a measurement, polls the ready flag under a bound, then checks the cycle counts.
  task automatic meas(input logic [15:0] ca, input logic [3:0] p, input int nd, input int ns);
    pat <= p;
    n_dec = 0;
    n_set = 0;
    n_bg = 0;
    n_tmp = 0;
    wreg(ADDR_CFG_A, ca);
    v = 16'h0000;
    for (int i = 0; i < 3000 && v[15] !== 1'b1; i++) begin
      rreg(ADDR_RESULT_STAT, v);
    end
    if (v[15] !== 1'b1) begin
      error_cnt++;
      $display("Error timeout waiting for ready");
      complete_run();
    end
    chk("decim cycles", 16'(n_dec), 16'(nd));
    chk("settle cycles", 16'(n_set), 16'(ns));
    chk("sensor", {12'h000, sensor}, {12'h000, ca[SENSOR_MSB:SENSOR_LSB]});
  endtask
  // Reset values, with a write to a read-only word and an unmapped read among them.
  task automatic t_reset();
    logic [8:0] a[9] = '{ADDR_CFG_A, ADDR_CFG_B, 9'h003, ADDR_SPIN, ADDR_OUT_OPT, ADDR_BG_TEMP,
      ADDR_RESULT_LOW, ADDR_RESULT_STAT, ADDR_TEMP_RES};
    wreg(ADDR_RESULT_LOW, 16'hFFFF);
    foreach (a[i]) begin
      rchk(a[i], REG_RESET);
    end
    $display("test reset done");
  endtask
  // Single phase runs with plain, zero and long decimation lengths.
  task automatic t_single();
    wreg(ADDR_OUT_OPT, 16'h0002);
    wreg(ADDR_CFG_B, 16'h0003);
    meas(16'h0003, 4'hF, 2, 3);
    rchk(ADDR_RESULT_STAT, 16'h8000);
    chk("ready pin", {15'h0000, rdy_out}, 16'h0001);
    rchk(ADDR_RESULT_LOW, 16'h0002);
    rchk(ADDR_RESULT_STAT, 16'h0000);
    chk("ready pin", {15'h0000, rdy_out}, 16'h0000);
    meas(16'h0001, 4'h0, 1, 3);
    rchk(ADDR_RESULT_STAT, 16'h8003);
    rchk(ADDR_RESULT_LOW, 16'hFFFF);
    wreg(ADDR_CFG_B, 16'h0103);
    meas(16'h0003, 4'hF, 258, 3);
    rchk(ADDR_RESULT_LOW, 16'h0102);
    $display("test single done");
  endtask
  // Four-phase and two-phase spinning sums.
  task automatic t_spin();
    wreg(ADDR_CFG_B, 16'h0003);
    wreg(ADDR_SPIN, 16'h1400);
    meas(16'h0003, 4'hA, 8, 12);
    rchk(ADDR_RESULT_LOW, 16'h0008);
    wreg(ADDR_SPIN, 16'h0000);
    wreg(ADDR_CFG_B, 16'h1003);
    meas(16'h0003, 4'h1, 4, 6);
    rchk(ADDR_RESULT_LOW, 16'h0004);
    $display("test spin done");
  endtask
  // Alternate readout of temperature, magnetic and range-warned results.
  task automatic t_alt();
    wreg(ADDR_SPIN, 16'h1400);
    wreg(ADDR_CFG_B, 16'h0003);
    wreg(ADDR_OUT_OPT, 16'h0003);
    meas(16'h1003, 4'h1, 4, 6);
    chk("temp cycles", 16'(n_tmp), 16'h000F);
    rchk(ADDR_CFG_A, 16'h0004);
    wreg(ADDR_CFG_A, 16'h0000);
    rchk(ADDR_RESULT_STAT, 16'h0000);
    meas(16'h0003, 4'hA, 8, 12);
    rchk(ADDR_CFG_A, 16'h0004);
    wreg(ADDR_CFG_A, 16'h0000);
    warn <= 1'b1;
    meas(16'h0003, 4'hA, 8, 12);
    rchk(ADDR_CFG_A, 16'h7FFF);
    wreg(ADDR_CFG_A, 16'h0000);
    $display("test alternate done");
  endtask
  // Parity, sequence number and range warning placed from the top of the result word.
  task automatic t_insert();
    wreg(ADDR_OUT_OPT, 16'h003A);
    wreg(ADDR_SPIN, 16'h0000);
    seq <= 2'b10;
    meas(16'h0003, 4'hF, 2, 3);
    @(posedge clk);
    warn <= 1'b0;
    rchk(ADDR_RESULT_LOW, 16'hD002);
    $display("test insert done");
  endtask
  // A long decimation is cancelled midway and must publish nothing.
  task automatic t_abort();
    wreg(ADDR_OUT_OPT, 16'h0002);
    wreg(ADDR_CFG_B, 16'h0703);
    wreg(ADDR_CFG_A, 16'h00FF);
    repeat (20) @(posedge clk);
    #1;
    chk("decim on", {15'h0000, mod_en}, 16'h0001);
    wreg(ADDR_CFG_A, 16'h00FE);
    @(posedge clk);
    #1;
    chk("decim off", {15'h0000, mod_en}, 16'h0000);
    repeat (50) @(posedge clk);
    rchk(ADDR_RESULT_STAT, 16'h0000);
    rchk(ADDR_RESULT_LOW, 16'h0002);
    $display("test abort done");
  endtask
  // Walks all pin modes with chip select high and low for one ready level.
  task automatic pin_loop(input logic rdy);
    logic drive;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 2; c++) begin
        wreg(ADDR_OUT_OPT, 16'(m * 2));
        cs_n <= c[0];
        repeat (5) @(posedge clk);
        drive = !(m[1] && rdy) && (m[0] || !c[0]);
        chk("ready enable", {15'h0000, rdy_oe_n}, {15'h0000, !drive});
        if (drive) begin
          chk("ready level", {15'h0000, rdy_out}, {15'h0000, rdy && !m[1]});
        end
      end
    end
  endtask
  // Ready pin in every mode, set and cleared.
  task automatic t_pins();
    wreg(ADDR_CFG_B, 16'h0003);
    meas(16'h0503, 4'hF, 2, 3);
    pin_loop(1'b1);
    rreg(ADDR_RESULT_LOW, v);
    pin_loop(1'b0);
    cs_n <= 1'b0;
    $display("test pins done");
  endtask
  // Background temperature over two windows of four slots.
  task automatic t_bg();
    wreg(ADDR_OUT_OPT, 16'h0002);
    wreg(ADDR_CFG_B, 16'h0005);
    wreg(ADDR_SPIN, 16'h1400);
    wreg(ADDR_BG_TEMP, 16'h0001);
    meas(16'h0003, 4'h5, 8, 20);
    chk("bg cycles", 16'(n_bg), 16'h000C);
    rchk(ADDR_TEMP_RES, 16'h0000);
    rreg(ADDR_RESULT_LOW, v);
    meas(16'h0003, 4'h5, 8, 20);
    rchk(ADDR_TEMP_RES, 16'h000C);
    $display("test background done");
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_spin();
    t_alt();
    t_insert();
    t_abort();
    t_pins();
    t_bg();
    complete_run();
  end
endmodule // hall_measurement_control_test
